// File: verilog/bdc_host.sv
// module: bus-master side of the daisy-chained backplane port
module bdc_host (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       clk_en,
  // user command port
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire logic                       cmd_write,
  input  wire logic                       cmd_io_page,
  input  wire logic [bdc_pkg::DAL_W-1:0]  cmd_addr,
  input  wire logic [bdc_pkg::DAL_W-1:0]  cmd_wdata,
  output logic                            rsp_valid,
  output logic                            rsp_is_vector,
  output logic      [bdc_pkg::DAL_W-1:0]  rsp_rdata,
  input  wire logic                       init_req,
  input  wire logic                       iak_enable,
  input  wire logic                       refresh_busy,
  output logic                            dma_granted,
  // backplane pins, active low except the active-high output enable
  output logic                            int_ack_chain_out_n,
  input  wire logic [bdc_pkg::IRQ_LEVELS-1:0] int_request_level_n,
  output logic                            io_page_select_n,
  output logic                            dma_grant_chain_out_n,
  input  wire logic                       dma_mastership_request_n,
  output logic                            bus_initialize_n,
  output logic                            data_input_strobe_n,
  input  wire logic [bdc_pkg::DAL_W-1:0]  shared_addr_data_lines_n_in,
  output logic      [bdc_pkg::DAL_W-1:0]  shared_addr_data_lines_n_out,
  output logic                            shared_addr_data_lines_n_oe
);
  localparam int unsigned SYNC_W = bdc_pkg::DAL_W + bdc_pkg::IRQ_LEVELS + 1;

  bdc_pkg::bdc_state_t              state_reg;   // sequencer state
  bdc_pkg::bdc_state_t              state_next;
  logic [bdc_pkg::CNT_W-1:0]        cnt_reg;     // cycles left in the phase
  logic [bdc_pkg::CNT_W-1:0]        cnt_next;
  logic [SYNC_W-1:0]                sync_q;      // synchronised pin inputs
  logic [bdc_pkg::DAL_W-1:0]        dal_in_s;    // lines, still active low
  logic [bdc_pkg::IRQ_LEVELS-1:0]   irq_s_n;     // request levels, active low
  logic                             dma_req;     // synced request, active high
  logic                             any_irq;
  logic                             cmd_take;
  logic                             phase_done;
  logic                             write_reg;   // latched command fields
  logic                             io_reg;
  logic [bdc_pkg::DAL_W-1:0]        addr_reg;
  logic [bdc_pkg::DAL_W-1:0]        wdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // every pin input crosses two flops before use
  bdc_sync #(
    .W       (SYNC_W),
    .RST_VAL ({SYNC_W{bdc_pkg::LINE_NEG}})
  ) u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .d      ({shared_addr_data_lines_n_in, int_request_level_n, dma_mastership_request_n}),
    .q      (sync_q)
  );

  assign dal_in_s   = sync_q[SYNC_W-1 -: bdc_pkg::DAL_W];
  assign irq_s_n    = sync_q[bdc_pkg::IRQ_LEVELS:1];
  assign dma_req    = ~sync_q[0];
  assign any_irq    = ~&irq_s_n;                      // some level 4..7 pulled low
  assign cmd_take   = cmd_valid && cmd_ready;
  assign phase_done = (cnt_reg == '0);

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic; idle priority is initialize, command, grant, acknowledge
  always_comb begin
    state_next = state_reg;
    cnt_next   = (cnt_reg == '0) ? cnt_reg : cnt_reg - 1'b1;
    case (state_reg)
      bdc_pkg::ST_IDLE: begin
        if (init_req) begin
          state_next = bdc_pkg::ST_INIT;
          cnt_next   = bdc_pkg::INIT_CYC - 1'b1;
        end else if (cmd_take) begin
          state_next = bdc_pkg::ST_ADDR;              // address goes out first
          cnt_next   = bdc_pkg::ADDR_CYC - 1'b1;
        end else if (dma_req && !refresh_busy) begin
          state_next = bdc_pkg::ST_GRANT;             // grant held off during refresh
        end else if (iak_enable && any_irq) begin
          state_next = bdc_pkg::ST_IAK;
          cnt_next   = bdc_pkg::DATA_CYC - 1'b1;
        end
      end
      bdc_pkg::ST_INIT: begin
        if (phase_done) begin
          state_next = bdc_pkg::ST_IDLE;              // back to state 0
        end
      end
      bdc_pkg::ST_ADDR: begin
        if (phase_done) begin
          state_next = write_reg ? bdc_pkg::ST_WRITE : bdc_pkg::ST_READ;
          cnt_next   = bdc_pkg::DATA_CYC - 1'b1;
        end
      end
      bdc_pkg::ST_WRITE, bdc_pkg::ST_READ, bdc_pkg::ST_IAK: begin
        if (phase_done) begin
          state_next = bdc_pkg::ST_IDLE;
        end
      end
      bdc_pkg::ST_GRANT: begin
        // the chain owns the bus until the requester drops its request
        if (!dma_req) begin
          state_next = bdc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = bdc_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and counter; reset walks through an initialize pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= bdc_pkg::ST_INIT;
      cnt_reg   <= bdc_pkg::INIT_CYC - 1'b1;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latch the command when it is taken; cleared on initialize
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      write_reg <= 1'b0;
      io_reg    <= 1'b0;
      addr_reg  <= '0;
      wdata_reg <= '0;
    end else if (clk_en) begin
      if (state_reg == bdc_pkg::ST_INIT) begin
        write_reg <= 1'b0;
        io_reg    <= 1'b0;
        addr_reg  <= '0;
        wdata_reg <= '0;
      end else if (cmd_take && !init_req) begin
        write_reg <= cmd_write;
        io_reg    <= cmd_io_page;
        // inside the I/O page only the low thirteen bits carry address
        addr_reg  <= cmd_io_page ? {{(bdc_pkg::DAL_W - bdc_pkg::IO_ADDR_W){1'b0}},
                                    cmd_addr[bdc_pkg::IO_ADDR_W-1:0]} : cmd_addr;
        wdata_reg <= cmd_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers, all registered from the next state so pins track state_reg
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_initialize_n             <= 1'b0;
      int_ack_chain_out_n          <= bdc_pkg::LINE_NEG;
      dma_grant_chain_out_n        <= bdc_pkg::LINE_NEG;
      io_page_select_n             <= bdc_pkg::LINE_NEG;
      data_input_strobe_n          <= bdc_pkg::LINE_NEG;
      shared_addr_data_lines_n_out <= bdc_pkg::DAL_IDLE;
      shared_addr_data_lines_n_oe  <= 1'b0;
      cmd_ready                    <= 1'b0;
      dma_granted                  <= 1'b0;
    end else if (clk_en) begin
      bus_initialize_n      <= (state_next != bdc_pkg::ST_INIT);
      // first link of the grant chain; the nearest device sees it first
      dma_grant_chain_out_n <= (state_next != bdc_pkg::ST_GRANT);
      dma_granted           <= (state_next == bdc_pkg::ST_GRANT);
      // acknowledge goes out with the data-input strobe
      int_ack_chain_out_n   <= (state_next != bdc_pkg::ST_IAK);
      data_input_strobe_n   <= !(state_next == bdc_pkg::ST_READ || state_next == bdc_pkg::ST_IAK);
      // page select framed over the whole cycle of an I/O access
      io_page_select_n      <= !(io_next_cycle(state_next) && io_next_page());
      cmd_ready             <= (state_next == bdc_pkg::ST_IDLE) && !init_req;
      // the sixteen lines carry address, then write data
      if (state_next == bdc_pkg::ST_ADDR) begin
        shared_addr_data_lines_n_out <= ~addr_next();
        shared_addr_data_lines_n_oe  <= 1'b1;
      end else if (state_next == bdc_pkg::ST_WRITE) begin
        shared_addr_data_lines_n_out <= ~wdata_reg;
        shared_addr_data_lines_n_oe  <= 1'b1;
      end else begin
        shared_addr_data_lines_n_out <= bdc_pkg::DAL_IDLE;
        shared_addr_data_lines_n_oe  <= 1'b0;
      end
    end
  end

  // command fields as they will stand next cycle (fresh on the take edge)
  function automatic logic io_next_page();
    io_next_page = cmd_take ? cmd_io_page : io_reg;
  endfunction : io_next_page

  function automatic logic [bdc_pkg::DAL_W-1:0] addr_next();
    if (cmd_take && cmd_io_page) begin
      addr_next = {{(bdc_pkg::DAL_W - bdc_pkg::IO_ADDR_W){1'b0}}, cmd_addr[bdc_pkg::IO_ADDR_W-1:0]};
    end else if (cmd_take) begin
      addr_next = cmd_addr;
    end else begin
      addr_next = addr_reg;
    end
  endfunction : addr_next

  function automatic logic io_next_cycle(input bdc_pkg::bdc_state_t s);
    io_next_cycle = (s == bdc_pkg::ST_ADDR) || (s == bdc_pkg::ST_WRITE) || (s == bdc_pkg::ST_READ);
  endfunction : io_next_cycle

  ////////////////////////////////////////////////////////////////////////////
  // read data or vector sampled on the last data cycle; one-cycle pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_valid     <= 1'b0;
      rsp_is_vector <= 1'b0;
      rsp_rdata     <= '0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      if (phase_done && (state_reg == bdc_pkg::ST_READ || state_reg == bdc_pkg::ST_IAK)) begin
        rsp_valid     <= 1'b1;
        rsp_is_vector <= (state_reg == bdc_pkg::ST_IAK);
        rsp_rdata     <= ~dal_in_s;                   // lines are active low
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks on what this master drives
  a_iak_with_strobe: assert property (@(posedge clk) disable iff (!rst_n)
    !int_ack_chain_out_n |-> !data_input_strobe_n && !shared_addr_data_lines_n_oe)
    else $error("acknowledge out without data-input strobe");

  a_grant_needs_req: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(dma_grant_chain_out_n) |-> $past(dma_req))
    else $error("grant asserted with no request pending");

  a_grant_refresh: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(dma_grant_chain_out_n) |-> !$past(refresh_busy))
    else $error("grant issued during refresh");

  a_grant_bus_free: assert property (@(posedge clk) disable iff (!rst_n)
    !dma_grant_chain_out_n |-> !shared_addr_data_lines_n_oe && int_ack_chain_out_n && bus_initialize_n)
    else $error("master drives bus while grant is out");

  a_init_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !bus_initialize_n |-> dma_grant_chain_out_n && int_ack_chain_out_n && !shared_addr_data_lines_n_oe)
    else $error("bus activity during initialize");

  a_io_addr_low: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == bdc_pkg::ST_ADDR && !io_page_select_n) |->
      shared_addr_data_lines_n_out[bdc_pkg::DAL_W-1:bdc_pkg::IO_ADDR_W] == '1)
    else $error("upper address bits set inside the I/O page");

  a_addr_before_data: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(data_input_strobe_n) && int_ack_chain_out_n) |-> $past(state_reg == bdc_pkg::ST_ADDR))
    else $error("read strobe without a preceding address phase");

  a_io_sel_framed: assert property (@(posedge clk) disable iff (!rst_n)
    !io_page_select_n |-> io_next_cycle(state_reg) && io_reg)
    else $error("page select outside an I/O page access");

  a_rsp_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid && clk_en) |=> !rsp_valid)
    else $error("response valid longer than one cycle");
endmodule : bdc_host

// File: common/bdc_pkg.sv
// package: timing, widths and state encoding for the backplane daisy-chain host
// How it works
// - master asserts page select for I/O page
// - arbitrator asserts grant to hand mastership
// - grant leaves arbitrator, reaches nearest device first
// - DMA transfers never disturb memory refresh; here a grant waits for refresh_busy low but is kept once out
// - address and data share sixteen lines
// - master drives address first, then data
// - processor acknowledges with data-input strobe together
package bdc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;        // 100 MHz system clock
  localparam int unsigned DAL_W         = 16;        // shared address/data lines
  localparam int unsigned IO_ADDR_W     = 13;        // address bits inside the I/O page
  localparam int unsigned IRQ_LEVELS    = 4;         // request levels 4..7
  localparam int unsigned CNT_W         = 10;        // phase counter width
  // phase lengths in ns; counts round up as these are least times
  localparam int unsigned T_ADDR_NS     = 150;       // address setup on the lines
  localparam int unsigned T_DATA_NS     = 300;       // data phase length
  localparam int unsigned T_INIT_NS     = 10000;     // initialize pulse length
  localparam logic [CNT_W-1:0] ADDR_CYC = CNT_W'((T_ADDR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] DATA_CYC = CNT_W'((T_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] INIT_CYC = CNT_W'((T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DAL_W-1:0] DAL_IDLE = 16'hFFFF;  // released lines read high
  localparam logic             LINE_NEG = 1'b1;      // negated level of an active-low line
  // host sequencer states; idle is state 0
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INIT,
    ST_ADDR,
    ST_WRITE,
    ST_READ,
    ST_IAK,
    ST_GRANT
  } bdc_state_t;
endpackage : bdc_pkg

// File: verilog/bdc_sync.sv
// module: two-stage synchroniser for a bundle of pin inputs
module bdc_sync #(
  parameter int unsigned     W       = 1,
  parameter logic [W-1:0]    RST_VAL = '1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;  // first stage, read only by the second

  ////////////////////////////////////////////////////////////////////////////
  // two flops in series; reset to the negated (high) level of the lines
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else if (clk_en) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : bdc_sync

// File: tb/bdc_dev_model.sv
// model: one daisy-chained device slot facing the host, with a downstream neighbour
module bdc_dev_model #(
  parameter logic [15:0] VEC = 16'h00a4  // interrupt vector, arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        ack_in_n,
  output logic             ack_out_n,
  output logic [3:0]       irq_n,
  input  wire logic        sel_n,
  input  wire logic        grant_in_n,
  output logic             grant_out_n,
  output logic             req_n,
  input  wire logic        init_n,
  input  wire logic        strobe_n,
  input  wire logic [15:0] dal_host_n,
  input  wire logic        dal_oe,
  output logic [15:0]      dal_dev_n,
  input  wire logic [3:0]  own_irq,
  input  wire logic [3:0]  down_irq,
  input  wire logic        own_req,
  input  wire logic        down_req,
  output logic             got_grant,
  output logic             kept_ack,
  output logic [15:0]      mem_reg,
  output logic [12:0]      io_addr_reg
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        oe_d;      // lines driven last cycle
  logic [15:0] last_reg;  // last true-polarity word seen
  logic        keep;      // own request is the top one
  // one-hot levels: numeric order matches priority order
  assign keep        = (|own_irq) && (own_irq >= down_irq);
  assign irq_n       = ~(own_irq | down_irq);
  assign kept_ack    = keep && !ack_in_n;
  assign ack_out_n   = ack_in_n | keep;
  assign req_n       = ~(own_req | down_req);
  assign got_grant   = !grant_in_n && own_req;
  assign grant_out_n = grant_in_n | own_req;
  // released lines float to the pull-up level, never the last value
  always_comb begin
    dal_dev_n = 16'hffff;
    if (!strobe_n && ack_in_n) begin
      dal_dev_n = ~mem_reg;
    end else if (!strobe_n && keep) begin
      dal_dev_n = ~VEC;
    end
  end
  // address first, data later on the same lines
  always_ff @(posedge clk) begin
    oe_d <= dal_oe;
    if (dal_oe) begin
      last_reg <= ~dal_host_n;
    end
    if (!init_n) begin
      mem_reg     <= 16'h0000;
      io_addr_reg <= 13'h0000;
    end else begin
      if (dal_oe && !oe_d && !sel_n) begin
        io_addr_reg <= ~dal_host_n[12:0];
      end
      if (!dal_oe && oe_d && strobe_n) begin
        mem_reg <= last_reg;
      end
    end
  end
endmodule : bdc_dev_model

// File: tb/tb_bdc_host.sv
// testbench: host port against one daisy-chained device model
module tb_bdc_host;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0, cmd_io_page = 1'b0;
  logic init_req = 1'b0, iak_enable = 1'b0, refresh_busy = 1'b0, own_req = 1'b0, down_req = 1'b0;
  logic [15:0] cmd_addr = 16'h0000, cmd_wdata = 16'h0000, rd, dal_out, dal_dev, rsp_rdata, mem_reg;
  logic [3:0]  own_irq = 4'h0, down_irq = 4'h0, irq_n;
  logic [12:0] io_addr_reg;
  logic cmd_ready, rsp_valid, rsp_is_vector, dma_granted, ack_n, sel_n, grant_n, req_n, init_n;
  logic strobe_n, dal_oe, ack_out_n, grant_out_n, got_grant, kept_ack;
  wire logic [15:0] dal_wire = (dal_oe ? dal_out : 16'hffff) & dal_dev;  // wired lines
  int error_cnt = 0;
  int n_checks = 0;
  bdc_host u_dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_io_page(cmd_io_page), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_is_vector(rsp_is_vector), .rsp_rdata(rsp_rdata), .init_req(init_req),
    .iak_enable(iak_enable), .refresh_busy(refresh_busy), .dma_granted(dma_granted),
    .int_ack_chain_out_n(ack_n), .int_request_level_n(irq_n), .io_page_select_n(sel_n),
    .dma_grant_chain_out_n(grant_n), .dma_mastership_request_n(req_n), .bus_initialize_n(init_n),
    .data_input_strobe_n(strobe_n), .shared_addr_data_lines_n_in(dal_wire),
    .shared_addr_data_lines_n_out(dal_out), .shared_addr_data_lines_n_oe(dal_oe));
  bdc_dev_model u_dev (.clk(clk), .ack_in_n(ack_n), .ack_out_n(ack_out_n), .irq_n(irq_n), .sel_n(sel_n),
    .grant_in_n(grant_n), .grant_out_n(grant_out_n), .req_n(req_n), .init_n(init_n), .strobe_n(strobe_n),
    .dal_host_n(dal_out), .dal_oe(dal_oe), .dal_dev_n(dal_dev), .own_irq(own_irq), .down_irq(down_irq),
    .own_req(own_req), .down_req(down_req), .got_grant(got_grant), .kept_ack(kept_ack),
    .mem_reg(mem_reg), .io_addr_reg(io_addr_reg));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // inputs always change 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  // one access; checks the pins along the walk, then waits for idle
  task automatic do_cmd(input logic w, input logic io, input logic [15:0] a, input logic [15:0] d);
    int n;
    {cmd_valid, cmd_write, cmd_io_page, cmd_addr, cmd_wdata} = {1'b1, w, io, a, d};
    cyc(1);
    cmd_valid = 1'b0;
    cyc(1);
    chk("oe", 16'(dal_oe), 16'h0001);
    chk("addr", dal_out, ~(io ? {3'h0, a[12:0]} : a));
    chk("sel", 16'(sel_n), 16'(!io));
    cyc(15);
    chk("strobe", 16'(strobe_n), 16'(w));
    if (w) chk("wdata", dal_out, ~d);
    for (n = 0; n < 40 && rsp_valid !== 1'b1 && !w; n++) cyc(1);
    // response lands ADDR_CYC+DATA_CYC edges after the take edge; 16 have passed here
    if (!w) chk("rsp time", 16'(n), 16'(bdc_pkg::ADDR_CYC + bdc_pkg::DATA_CYC) - 16'd16);
    if (!w) chk("rsp kind", 16'(rsp_is_vector), 16'h0000);
    rd = rsp_rdata;
    for (n = 0; n < 100 && cmd_ready !== 1'b1; n++) cyc(1);
    // the device model latches write data one edge after the lines are released
    cyc(1);
  endtask : do_cmd
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_boot();
    int n;
    chk("init low", 16'(init_n), 16'h0000);
    for (n = 0; n < 1100 && cmd_ready !== 1'b1; n++) cyc(1);
    chk("init len", 16'(n >= 1000 && n < 1004), 16'h0001);
    chk("boot mem", mem_reg, 16'h0000);
    $display("test boot done");
  endtask : t_boot
  // io page boundary address, then a plain read back
  task automatic t_rw();
    do_cmd(1'b1, 1'b1, 16'hffff, 16'ha5c3);
    chk("io addr", 16'(io_addr_reg), 16'h1fff);
    chk("mem", mem_reg, 16'ha5c3);
    do_cmd(1'b0, 1'b0, 16'h2000, 16'h0000);
    chk("read", rd, 16'ha5c3);
    $display("test rw done");
  endtask : t_rw
  // levels 4..7 kept in turn, then a higher downstream request passed on
  task automatic t_iak();
    int n;
    for (int l = 0; l < 5; l++) begin
      own_irq = (l < 4) ? 4'(1 << l) : 4'h1;
      down_irq = (l < 4) ? 4'h0 : 4'h8;
      iak_enable = 1'b1;
      for (n = 0; n < 10 && ack_n !== 1'b0; n++) cyc(1);
      chk("kept", 16'(kept_ack), 16'(l < 4));
      chk("pass", 16'(ack_out_n), 16'(l < 4));
      for (n = 0; n < 40 && rsp_valid !== 1'b1; n++) cyc(1);
      chk("vec flag", 16'(rsp_is_vector), 16'h0001);
      chk("vector", rsp_rdata, (l < 4) ? 16'h00a4 : 16'h0000);
      {own_irq, down_irq, iak_enable} = 9'h000;
      cyc(4);
    end
    $display("test iak done");
  endtask : t_iak
  // grant held off by refresh, kept by requester, passed by non-requester
  task automatic t_grant();
    int n;
    {own_req, refresh_busy} = 2'b11;
    cyc(10);
    chk("refresh", 16'(grant_n), 16'h0001);
    refresh_busy = 1'b0;
    for (n = 0; n < 8 && dma_granted !== 1'b1; n++) cyc(1);
    chk("granted", 16'(grant_n), 16'h0000);
    chk("accept", 16'({got_grant, grant_out_n}), 16'h0003);
    own_req = 1'b0;
    cyc(5);
    chk("release", 16'(dma_granted), 16'h0000);
    down_req = 1'b1;
    for (n = 0; n < 8 && dma_granted !== 1'b1; n++) cyc(1);
    chk("passed", 16'({got_grant, grant_out_n}), 16'h0000);
    down_req = 1'b0;
    cyc(5);
    $display("test grant done");
  endtask : t_grant
  // initialize after a write clears the device
  task automatic t_init();
    int n;
    do_cmd(1'b1, 1'b1, 16'h0123, 16'h5a5a);
    chk("pre mem", mem_reg, 16'h5a5a);
    init_req = 1'b1;
    cyc(1);
    init_req = 1'b0;
    cyc(1);
    chk("init pin", 16'(init_n), 16'h0000);
    for (n = 0; n < 1100 && cmd_ready !== 1'b1; n++) cyc(1);
    chk("clr", {mem_reg[15:13], io_addr_reg | mem_reg[12:0]}, 16'h0000);
    $display("test init done");
  endtask : t_init
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #5 clk = ~clk;
  // watchdog: the run needs about 2400 cycles
  initial begin
    #200_000;
    error_cnt++;
    stop_test();
  end
  initial begin
    cyc(6);
    rst_n = 1'b1;
    t_boot();
    t_rw();
    t_iak();
    t_grant();
    t_init();
    stop_test();
  end
endmodule : tb_bdc_host
